// File: rtl/bmc_pkg.sv
// Package for the bus-master control register block of a DMA engine.
// Assumes a single PCI clock domain; shared by the register and arbiter.
package bmc_pkg;
    localparam logic [7:0] BMC_OFFSET = 8'h00;
    localparam int BL_LSB = 8;
    localparam int BL_MSB = 13;
    localparam int BBE_BIT = 7;
    localparam int SKIP_LSB = 2;
    localparam int SKIP_MSB = 6;
    localparam int ARB_BIT = 1;
    localparam int SWR_BIT = 0;
    localparam int CA_LSB = 14;
    localparam int CA_MSB = 15;
    localparam int DBE_BIT = 20;
    localparam int WAIT_BIT = 21;
    localparam logic [31:0] BMC_WMASK = 32'h0030_FFFF;
    localparam logic [31:0] BMC_RESET = 32'h0000_0010;
    localparam logic [4:0] SKIP_RESET = 5'h04;
    localparam int SWR_TIME_CLKS = 4;
    localparam logic [2:0] SWR_CYCLES = 3'(SWR_TIME_CLKS);
    localparam logic [5:0] BL_REF_CA = 6'h00;
    localparam logic [1:0] CA_8 = 2'h1;
    localparam logic [1:0] CA_16 = 2'h2;
    localparam logic [1:0] CA_32 = 2'h3;

    typedef struct packed {
        logic [5:0] burst_longword_limit;
        logic buffer_byte_order;
        logic [4:0] skip;
        logic tx_rx_bus_priority;
        logic [1:0] cache_alignment_field;
        logic desc_byte_order;
        logic wait_state;
    } bmc_cfg_t;

    typedef struct packed {
        logic tx;
        logic rx;
    } bmc_req_t;
endpackage : bmc_pkg

// File: rtl/bmc_arbiter.sv
// Internal bus arbiter between transmit and receive processes.
// Assumes requests are held until granted and dropped when done.
`timescale 1ns/1ps
`default_nettype none
module bmc_arbiter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic soft_rst,
    // Control
    input wire logic tx_rx_bus_priority,
    input wire bmc_pkg::bmc_req_t req,
    output logic [1:0] grant
);
    logic last_rx;
    logic next_last_rx;
    logic [1:0] next_grant;

    always_comb
    begin
        next_grant = 2'h0;
        next_last_rx = last_rx;
        if (grant[0] && req.rx)
        begin
            next_grant = grant;
        end
        else if (grant[1] && req.tx)
        begin
            next_grant = grant;
        end
        else if (req.rx && req.tx)
        begin
            if (tx_rx_bus_priority && last_rx)
                next_grant = 2'h2;
            else
                next_grant = 2'h1;
        end
        else if (req.rx)
            next_grant = 2'h1;
        else if (req.tx)
            next_grant = 2'h2;
        if (next_grant != 2'h0)
            next_last_rx = next_grant[0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            grant <= 2'h0;
            last_rx <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                grant <= 2'h0;
                last_rx <= 1'b0;
            end
            else
            begin
                grant <= next_grant;
                last_rx <= next_last_rx;
            end
        end
    end

    rx_first_a: assert property (@(posedge clk) disable iff (rst)
        ce && !soft_rst && !tx_rx_bus_priority && req.rx && req.tx
        && grant == 2'h0 |=> grant == 2'h1)
        else $error("receive not preferred under fixed priority");
    fair_turn_a: assert property (@(posedge clk) disable iff (rst)
        ce && !soft_rst && tx_rx_bus_priority && req.rx && req.tx
        && grant == 2'h0 && last_rx |=> grant == 2'h2)
        else $error("transmit not given its turn");
    one_hot_a: assert property (@(posedge clk) disable iff (rst)
        grant != 2'h3)
        else $error("both processes granted");
    tx_grant_c: cover property (@(posedge clk) disable iff (rst)
        grant == 2'h2);
endmodule : bmc_arbiter
`default_nettype wire

// File: rtl/bmc_ctrl.sv
// Bus-master control register with software reset and burst limiting.
// Assumes a PCI target front end holding write/read strobes until TRDY.
// Behaviour
// - Each burst is capped at the burst length code 1..63, or by cache alignment when it is zero.
// - The buffer byte-order bit makes data buffers big endian when one, little endian when zero.
// - The next descriptor address is the current one plus the skip field in long words.
// - The skip field loads four after hardware or software reset.
// - With the priority bit one, transmit and receive share the internal bus equally.
// - With the priority bit zero, receive wins the internal bus over transmit unless transmit already holds it.
// - Writing one to the reset bit resets the internal state and reloads this register with its reset value.
// - The software reset lasts four clocks and the bit then clears itself.
// - A target access during software reset sees TRDY held off until it ends.
// - The software reset bit reads zero after hardware reset.
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // PCI target access
    input wire logic tgt_valid,
    input wire logic tgt_write,
    input wire logic [7:0] tgt_addr,
    input wire logic [31:0] tgt_wdata,
    input wire logic [3:0] tgt_be_n,
    output logic trdy_n,
    output logic [31:0] tgt_rdata,
    // Descriptor walk
    input wire logic desc_step,
    input wire logic desc_load,
    input wire logic [31:0] desc_base,
    output logic [31:0] desc_addr,
    // Burst and data path
    input wire logic [6:0] burst_count,
    output logic burst_stop,
    input wire logic [31:0] buf_in,
    output logic [31:0] buf_out,
    // Process arbitration
    input wire bmc_pkg::bmc_req_t proc_req,
    output logic [1:0] proc_grant,
    // Reset and configuration out to other blocks
    output logic soft_rst,
    output bmc_pkg::bmc_cfg_t cfg
);
    logic [31:0] reg_q;
    logic [31:0] next_reg_q;
    logic [2:0] swr_cnt;
    logic [2:0] next_swr_cnt;
    logic [31:0] next_desc_addr;
    logic next_trdy_n;
    logic [31:0] next_rdata;
    logic next_soft_rst;
    logic [6:0] limit;
    logic next_burst_stop;
    logic [31:0] next_buf_out;
    logic hit;
    logic [31:0] bemask;
    bmc_pkg::bmc_cfg_t next_cfg;

    assign hit = tgt_addr == bmc_pkg::BMC_OFFSET;
    assign bemask = {{8{~tgt_be_n[3]}}, {8{~tgt_be_n[2]}},
                     {8{~tgt_be_n[1]}}, {8{~tgt_be_n[0]}}};

    // Register, software reset timer and target handshake
    always_comb
    begin
        next_reg_q = reg_q;
        next_swr_cnt = swr_cnt;
        next_trdy_n = 1'b1;
        next_rdata = 32'h0000_0000;
        next_soft_rst = 1'b0;
        if (swr_cnt != 3'h0)
        begin
            next_swr_cnt = 3'(swr_cnt - 3'h1);
            next_soft_rst = swr_cnt != 3'h1;
            if (swr_cnt == 3'h1)
            begin
                next_reg_q = bmc_pkg::BMC_RESET;
                next_reg_q[bmc_pkg::SWR_BIT] = 1'b0;
            end
        end
        else if (tgt_valid && trdy_n)
        begin
            next_trdy_n = 1'b0;
            if (tgt_write && hit)
            begin
                next_reg_q = (reg_q & ~(bemask & bmc_pkg::BMC_WMASK))
                    | (tgt_wdata & bemask & bmc_pkg::BMC_WMASK);
                if (!tgt_be_n[0] && tgt_wdata[bmc_pkg::SWR_BIT])
                begin
                    next_swr_cnt = bmc_pkg::SWR_CYCLES;
                    next_soft_rst = 1'b1;
                end
            end
            else if (!tgt_write && hit)
                next_rdata = reg_q;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_q <= bmc_pkg::BMC_RESET;
            swr_cnt <= 3'h0;
            trdy_n <= 1'b1;
            tgt_rdata <= 32'h0000_0000;
            soft_rst <= 1'b0;
        end
        else if (ce)
        begin
            reg_q <= next_reg_q;
            swr_cnt <= next_swr_cnt;
            trdy_n <= next_trdy_n;
            tgt_rdata <= next_rdata;
            soft_rst <= next_soft_rst;
        end
    end

    // Configuration outputs, descriptor walker, burst limit, byte order
    always_comb
    begin
        next_cfg.burst_longword_limit = reg_q[bmc_pkg::BL_MSB:bmc_pkg::BL_LSB];
        next_cfg.buffer_byte_order = reg_q[bmc_pkg::BBE_BIT];
        next_cfg.skip = reg_q[bmc_pkg::SKIP_MSB:bmc_pkg::SKIP_LSB];
        next_cfg.tx_rx_bus_priority = reg_q[bmc_pkg::ARB_BIT];
        next_cfg.cache_alignment_field = reg_q[bmc_pkg::CA_MSB:bmc_pkg::CA_LSB];
        next_cfg.desc_byte_order = reg_q[bmc_pkg::DBE_BIT];
        next_cfg.wait_state = reg_q[bmc_pkg::WAIT_BIT];
        limit = {1'b0, cfg.burst_longword_limit};
        if (cfg.burst_longword_limit == bmc_pkg::BL_REF_CA)
        begin
            unique case (cfg.cache_alignment_field)
                bmc_pkg::CA_8: limit = 7'h08;
                bmc_pkg::CA_16: limit = 7'h10;
                bmc_pkg::CA_32: limit = 7'h20;
                default: limit = 7'h01;
            endcase
        end
        next_burst_stop = burst_count >= limit;
        next_desc_addr = desc_addr;
        if (desc_load)
            next_desc_addr = desc_base;
        else if (desc_step)
            next_desc_addr = desc_addr + {25'h0, cfg.skip, 2'h0};
        if (cfg.buffer_byte_order)
            next_buf_out = {buf_in[7:0], buf_in[15:8],
                            buf_in[23:16], buf_in[31:24]};
        else
            next_buf_out = buf_in;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg <= '0;
            cfg.skip <= bmc_pkg::SKIP_RESET;
            desc_addr <= 32'h0000_0000;
            burst_stop <= 1'b0;
            buf_out <= 32'h0000_0000;
        end
        else if (ce)
        begin
            cfg <= next_cfg;
            burst_stop <= next_burst_stop;
            buf_out <= next_buf_out;
            if (soft_rst)
                desc_addr <= 32'h0000_0000;
            else
                desc_addr <= next_desc_addr;
        end
    end

    bmc_arbiter u_arb (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .soft_rst(soft_rst),
        .tx_rx_bus_priority(cfg.tx_rx_bus_priority),
        .req(proc_req),
        .grant(proc_grant)
    );

    // Assertions
    swr_length_a: assert property (@(posedge clk) disable iff (rst)
        ce && $rose(soft_rst) |->
        soft_rst [*4] ##1 !soft_rst)
        else $error("software reset length wrong");
    trdy_hold_a: assert property (@(posedge clk) disable iff (rst)
        soft_rst |=> trdy_n)
        else $error("TRDY asserted during software reset");
    swr_clear_a: assert property (@(posedge clk) disable iff (rst)
        $fell(soft_rst) |-> !reg_q[bmc_pkg::SWR_BIT])
        else $error("reset bit not cleared");
    skip_reload_a: assert property (@(posedge clk) disable iff (rst)
        $fell(soft_rst) |-> reg_q[bmc_pkg::SKIP_MSB:bmc_pkg::SKIP_LSB]
        == bmc_pkg::SKIP_RESET)
        else $error("skip not reloaded after software reset");
    desc_step_a: assert property (@(posedge clk) disable iff (rst)
        ce && !soft_rst && desc_step && !desc_load |=>
        desc_addr == $past(desc_addr) + {25'h0, $past(cfg.skip), 2'h0})
        else $error("descriptor step wrong");
    burst_cap_a: assert property (@(posedge clk) disable iff (rst)
        ce && cfg.burst_longword_limit == 6'h04 && burst_count == 7'h04
        |=> burst_stop)
        else $error("burst not capped");
    byte_swap_a: assert property (@(posedge clk) disable iff (rst)
        ce && cfg.buffer_byte_order |=> buf_out[31:24] == $past(buf_in[7:0]))
        else $error("big endian swap missing");
    swr_start_a: assert property (@(posedge clk) disable iff (rst)
        ce && !soft_rst && swr_cnt == 3'h0 && tgt_valid && trdy_n
        && tgt_write && hit && !tgt_be_n[0] && tgt_wdata[0]
        |=> soft_rst)
        else $error("software reset not started");
    swr_c: cover property (@(posedge clk) $fell(soft_rst));
    read_c: cover property (@(posedge clk) !trdy_n && tgt_rdata != 32'h0);
    blocked_c: cover property (@(posedge clk) soft_rst && tgt_valid);
endmodule : bmc_ctrl
`default_nettype wire

// File: verif/bmc_host.sv
// Host bridge model: issues target accesses to the control register.
// Assumes trdy_n is active low and inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
    // Clock
    input wire logic clk,
    // Target access
    input wire logic trdy_n,
    input wire logic [31:0] tgt_rdata,
    output logic tgt_valid,
    output logic tgt_write,
    output logic [7:0] tgt_addr,
    output logic [31:0] tgt_wdata,
    output logic [3:0] tgt_be_n,
    // Transmit and receive requests
    output bmc_pkg::bmc_req_t proc_req
);
    logic ok = 1'b1;
    initial
    begin
        tgt_valid = 1'b0;
        tgt_write = 1'b0;
        tgt_addr = 8'h00;
        tgt_wdata = 32'h0;
        tgt_be_n = 4'hF;
        proc_req = '0;
    end
    task automatic set_req(input logic [1:0] r);
        @(negedge clk);
        proc_req = r;
    endtask : set_req
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        if (wr && a == 8'h00 && d[15:14] == 2'h0)
            d[15:14] = bmc_pkg::CA_8;
        @(negedge clk);
        if (wr)
            proc_req = '0;
        tgt_valid = 1'b1;
        tgt_write = wr;
        tgt_addr = a;
        tgt_wdata = d;
        tgt_be_n = 4'h0;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(negedge clk);
            if (trdy_n === 1'b0)
            begin
                ok = 1'b1;
                q = tgt_rdata;
            end
        end
        @(posedge clk);
        @(negedge clk);
        // Released lines show no stale value
        tgt_valid = 1'b0;
        tgt_addr = ~a;
        tgt_wdata = ~d;
        tgt_be_n = 4'hF;
    endtask : access
endmodule : bmc_host
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the bus-master control register block.
// Assumes the host model drives target accesses; ce is held high.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid, write, trdy_n, burst_stop, soft_rst;
    logic desc_step, desc_load;
    logic [7:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata, rdata, desc_base, desc_addr, buf_in, buf_out, q;
    logic [6:0] burst_count;
    logic [1:0] grant, g;
    bmc_pkg::bmc_req_t req;
    bmc_pkg::bmc_cfg_t cfg;
    int err_total = 0;
    int tests_run = 0;
    int sr_cnt = 0;
    int early = 0;
    always #5 clk = ~clk;
    always @(negedge clk)
    begin
        if (soft_rst === 1'b1)
            sr_cnt++;
        // A read answered while the software reset still runs
        if (soft_rst === 1'b1 && trdy_n === 1'b0 && write === 1'b0)
            early++;
    end
    bmc_host i_host (.clk(clk), .trdy_n(trdy_n), .tgt_rdata(rdata),
        .tgt_valid(valid), .tgt_write(write), .tgt_addr(addr),
        .tgt_wdata(wdata), .tgt_be_n(be_n), .proc_req(req));
    bmc_ctrl i_bmc_ctrl (.clk(clk), .rst(rst), .ce(1'b1),
        .tgt_valid(valid), .tgt_write(write), .tgt_addr(addr),
        .tgt_wdata(wdata), .tgt_be_n(be_n), .trdy_n(trdy_n),
        .tgt_rdata(rdata), .desc_step(desc_step), .desc_load(desc_load),
        .desc_base(desc_base), .desc_addr(desc_addr),
        .burst_count(burst_count), .burst_stop(burst_stop),
        .buf_in(buf_in), .buf_out(buf_out), .proc_req(req),
        .proc_grant(grant), .soft_rst(soft_rst), .cfg(cfg));
    task automatic summarize();
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        i_host.access(w, a, d, q);
        if (i_host.ok !== 1'b1)
        begin
            err_total++;
            summarize();
        end
    endtask : acc
    task automatic step(input logic ld, input logic st);
        @(negedge clk);
        desc_load = ld;
        desc_step = st;
        @(negedge clk);
        desc_load = 1'b0;
        desc_step = 1'b0;
    endtask : step
    task automatic t_regs();
        acc(0, 8'h00, 0);
        check("reset value", q, bmc_pkg::BMC_RESET);
        check("reset skip", 32'(cfg.skip), 32'h4);
        acc(1, 8'h00, 32'hFFFF_FFFE);
        acc(1, 8'h04, 32'h0);
        acc(0, 8'h04, 0);
        check("unmapped", q, 32'h0);
        acc(0, 8'h00, 0);
        check("fields", q, bmc_pkg::BMC_WMASK & 32'hFFFF_FFFE);
    endtask : t_regs
    task automatic t_burst();
        logic [5:0] code [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08,
            6'h10, 6'h20};
        logic [6:0] lim [7] = '{7'h08, 7'h01, 7'h02, 7'h04, 7'h08,
            7'h10, 7'h20};
        for (int i = 0; i < 7; i++)
        begin
            acc(1, 8'h00, {18'h1, code[i], 8'h10});
            burst_count = lim[i] - 7'h1;
            @(negedge clk);
            @(negedge clk);
            check("under limit", 32'(burst_stop), 32'h0);
            burst_count = lim[i];
            @(negedge clk);
            @(negedge clk);
            check("at limit", 32'(burst_stop), 32'h1);
        end
        burst_count = 7'h0;
    endtask : t_burst
    task automatic t_order();
        for (int b = 0; b < 2; b++)
        begin
            acc(1, 8'h00, 32'h4010 | (b << 7));
            buf_in = 32'h1122_3344;
            @(negedge clk);
            @(negedge clk);
            check("buffer", buf_out, b ? 32'h4433_2211 : buf_in);
        end
    endtask : t_order
    task automatic t_desc();
        acc(1, 8'h00, 32'h4014);
        desc_base = 32'h0000_1000;
        step(1, 0);
        check("desc load", desc_addr, 32'h1000);
        step(0, 1);
        check("desc step", desc_addr, 32'h1014);
    endtask : t_desc
    task automatic grab(output logic [1:0] r);
        int n;
        i_host.set_req(2'h3);
        for (n = 0; n < 6 && grant !== 2'h1 && grant !== 2'h2; n++)
            @(negedge clk);
        if (grant !== 2'h1 && grant !== 2'h2)
        begin
            err_total++;
            summarize();
        end
        r = grant;
        i_host.set_req(2'h0);
        repeat (3) @(negedge clk);
    endtask : grab
    task automatic t_arb();
        acc(1, 8'h00, 32'h4010);
        grab(g);
        check("rx first", 32'(g), 32'h1);
        grab(g);
        check("rx again", 32'(g), 32'h1);
        acc(1, 8'h00, 32'h4012);
        grab(g);
        grab(q[1:0]);
        check("alternate", 32'(q[1:0]), 32'({g[0], g[1]}));
    endtask : t_arb
    task automatic t_soft();
        sr_cnt = 0;
        early = 0;
        acc(1, 8'h00, 32'h40A5);
        acc(0, 8'h00, 0);
        check("after reset", q, bmc_pkg::BMC_RESET);
        check("reset cycles", 32'(sr_cnt), 32'h4);
        check("held off", 32'(soft_rst), 32'h0);
        check("early answer", 32'(early), 32'h0);
        check("desc cleared", desc_addr, 32'h0);
        check("skip reload", 32'(cfg.skip), 32'(bmc_pkg::SKIP_RESET));
    endtask : t_soft
    initial
    begin
        desc_step = 1'b0;
        desc_load = 1'b0;
        desc_base = 32'h0;
        burst_count = 7'h0;
        buf_in = 32'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_burst();
        t_order();
        t_desc();
        t_arb();
        t_soft();
        summarize();
    end
endmodule : testbench
`default_nettype wire
